// [core/ddr3_mode_pkg.sv]
package ddr3_mode_pkg;

  // Bank address values that select each mode register on an MRS command.
  localparam logic [2:0] MR0_SEL = 3'h0;
  localparam logic [2:0] MR1_SEL = 3'h1;
  localparam logic [2:0] MR2_SEL = 3'h2;

  // Width of the mode register operand carried on the address lines.
  localparam int MR_W = 17;

  // Mode register 0 field positions.
  localparam int MR0_CL_LO    = 4;
  localparam int MR0_DLL_RST  = 8;

  // Mode register 1 field positions.
  localparam int MR1_DLL_DIS  = 0;
  localparam int MR1_DRV_LO   = 1;
  localparam int MR1_RTT_B2   = 2;
  localparam int MR1_AL_LO    = 3;
  localparam int MR1_DRV_HI   = 5;
  localparam int MR1_RTT_B6   = 6;
  localparam int MR1_WLEVEL   = 7;
  localparam int MR1_RTT_B9   = 9;
  localparam int MR1_TDQS     = 11;
  localparam int MR1_QOFF     = 12;

  // Mode register 2 field positions.
  localparam int MR2_CWL_LO   = 3;
  localparam int MR2_RTTWR_LO = 9;

  // Values after reset: CL 5, CWL 5, DLL enabled, all options off.
  localparam logic [MR_W-1:0] MR0_RESET = 17'h00010;
  localparam logic [MR_W-1:0] MR1_RESET = 17'h00000;
  localparam logic [MR_W-1:0] MR2_RESET = 17'h00000;

  // Latency decoding: CL code 1..6 maps to 5..10, CWL code 0..3 maps to 5..8.
  localparam logic [2:0] CL_CODE_MIN  = 3'h1;
  localparam logic [2:0] CL_CODE_MAX  = 3'h6;
  localparam logic [3:0] CL_OFFSET    = 4'h4;
  localparam logic [3:0] CWL_OFFSET   = 4'h5;
  localparam logic [3:0] DLL_OFF_LAT  = 4'h6;

  // Additive latency encodings.
  localparam logic [1:0] AL_ZERO      = 2'h0;
  localparam logic [1:0] AL_CL_M1     = 2'h1;
  localparam logic [1:0] AL_CL_M2     = 2'h2;

  // Nominal termination codes {b9,b6,b2} and the RZQ divisor they give.
  localparam logic [2:0] RTT_OFF      = 3'h0;
  localparam logic [2:0] RTT_DIV4     = 3'h1;
  localparam logic [2:0] RTT_DIV2     = 3'h2;
  localparam logic [2:0] RTT_DIV6     = 3'h3;
  localparam logic [2:0] RTT_DIV12    = 3'h4;
  localparam logic [2:0] RTT_DIV8     = 3'h5;

  // DLL lock time in clock cycles after any DLL reset.
  localparam int          DLL_LOCK_CYCLES = 512;
  localparam logic [9:0]  DLL_LOCK_CNT    = 10'(DLL_LOCK_CYCLES);

  // Depth of a latency delay line; the longest delay is CL 10 or AL 9.
  localparam int DLY_DEPTH = 16;

  // Self refresh tracking states.
  typedef enum logic {SR_IDLE, SR_ACTIVE} sr_state_t;

endpackage

// [core/lat_pipe_if.sv]
`timescale 1ns/10ps
// Carries one command pulse into a delay line and the delayed pulse back.
interface lat_pipe_if;
  logic       pulse_in;  // Command strobe entering the line.
  logic [3:0] dly;       // Delay in clock cycles, zero passes straight through.
  logic       pulse_out; // Strobe after the programmed delay.
  modport owner (output pulse_in, output dly, input pulse_out);
  modport line  (input pulse_in, input dly, output pulse_out);
endinterface

// [core/lat_pipe.sv]
`timescale 1ns/10ps
// Variable delay line for command strobes; several commands may be in flight.
module lat_pipe (
  // Clock, reset and enable.
  input  wire logic clk_sys_i,
  input  wire logic rst_i,
  input  wire logic ce_i,
  // Strobe and delay from the owner.
  lat_pipe_if.line  lp
);

  // One bit per cycle of delay so back to back commands never collide.
  logic [ddr3_mode_pkg::DLY_DEPTH-1:0] shreg;

  // Shift the strobe along each enabled clock.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      shreg <= '0;
    end else if (ce_i) begin
      shreg <= {shreg[ddr3_mode_pkg::DLY_DEPTH-2:0], lp.pulse_in};
    end
  end

  // A delay of zero bypasses the flops; otherwise tap the matching stage.
  assign lp.pulse_out = (lp.dly == 4'h0) ? lp.pulse_in : shreg[lp.dly - 4'h1];

endmodule

// [core/ddr3_mode_latency_config.sv]
`timescale 1ns/10ps
module ddr3_mode_latency_config (
  // Clock, reset and clock enable.
  input  wire logic       clk_sys_i,
  input  wire logic       rst_i,
  input  wire logic       ce_i,
  // Mode register set command from the controller side.
  input  wire logic       mrs_i,
  input  wire logic [2:0] mrs_bank_i,
  input  wire logic [16:0] mrs_addr_i,
  // Column commands and self refresh control from the command decoder.
  input  wire logic       rd_cmd_i,
  input  wire logic       wr_cmd_i,
  input  wire logic       sr_enter_i,
  input  wire logic       sr_exit_i,
  input  wire logic       wr_burst_i,
  // Pins from outside the clock domain.
  input  wire logic       odt_pin_i,
  input  wire logic       org_x8_i,
  // Latency results.
  output logic [3:0]      cas_lat_o,
  output logic [3:0]      cas_wr_lat_o,
  output logic [3:0]      add_lat_o,
  output logic [4:0]      rd_lat_o,
  output logic [4:0]      wr_lat_o,
  output logic            cl_invalid_o,
  output logic            dll_lat_err_o,
  // Internal command strobes.
  output logic            rd_release_o,
  output logic            wr_release_o,
  output logic            rd_data_start_o,
  // DLL status.
  output logic            dll_on_o,
  output logic            dll_reset_o,
  output logic            dll_locking_o,
  // Output buffer and termination controls.
  output logic [1:0]      drive_sel_o,
  output logic            dq_drive_en_o,
  output logic            tdqs_en_o,
  output logic            dm_en_o,
  output logic [3:0]      rtt_div_o,
  output logic            rtt_on_o,
  output logic            rtt_use_wr_o,
  output logic            tdqs_term_o,
  output logic            wlevel_o
);

  // Stored mode registers; MR0 bit 8 is never stored since it self-clears.
  logic [16:0] mr0;
  logic [16:0] mr1;
  logic [16:0] mr2;
  // Two-flop synchronisers for the asynchronous pins.
  logic        odt_meta;
  logic        odt_sync;
  logic        x8_meta;
  logic        x8_sync;
  // Self refresh tracking and remembered DLL state at entry.
  ddr3_mode_pkg::sr_state_t sr_state;
  logic        dll_was_on;
  logic        sr_exit_reset;
  // DLL lock counter.
  logic [9:0]  lock_cnt;
  // Decoded values.
  logic [2:0]  cl_code;
  logic [3:0]  cl_val;
  logic [3:0]  al_val;
  logic [2:0]  rtt_code;
  logic [3:0]  next_rtt_div;
  logic        dll_reset_req;

  // Delay lines: additive latency for reads and writes, then CAS latency.
  lat_pipe_if al_rd ();
  lat_pipe_if al_wr ();
  lat_pipe_if cl_rd ();

  // Mode register writes: only reset or an MRS command changes them.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      mr0 <= ddr3_mode_pkg::MR0_RESET;
      mr1 <= ddr3_mode_pkg::MR1_RESET;
      mr2 <= ddr3_mode_pkg::MR2_RESET;
    end else if (ce_i && mrs_i) begin
      // Loading is legal only with banks idle; the controller keeps that.
      if (mrs_bank_i == ddr3_mode_pkg::MR0_SEL) begin
        // The DLL reset bit is a command, so it reads back as zero.
        mr0 <= mrs_addr_i & ~(17'h00001 << ddr3_mode_pkg::MR0_DLL_RST);
      end else if (mrs_bank_i == ddr3_mode_pkg::MR1_SEL) begin
        // Reserved bits are stored as given; the controller writes zero.
        mr1 <= mrs_addr_i;
      end else if (mrs_bank_i == ddr3_mode_pkg::MR2_SEL) begin
        mr2 <= mrs_addr_i;
      end
    end
  end

  // Synchronise the ODT pin and the organisation strap before any use.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      odt_meta <= 1'b0;
      odt_sync <= 1'b0;
      x8_meta  <= 1'b0;
      x8_sync  <= 1'b0;
    end else if (ce_i) begin
      odt_meta <= odt_pin_i;
      odt_sync <= odt_meta;
      x8_meta  <= org_x8_i;
      x8_sync  <= x8_meta;
    end
  end

  // CAS latency decode; reserved codes fall back to 5 and raise a flag.
  assign cl_code = mr0[ddr3_mode_pkg::MR0_CL_LO +: 3];
  always_comb begin
    if (cl_code >= ddr3_mode_pkg::CL_CODE_MIN && cl_code <= ddr3_mode_pkg::CL_CODE_MAX) begin
      cl_val = {1'b0, cl_code} + ddr3_mode_pkg::CL_OFFSET;
    end else begin
      cl_val = ddr3_mode_pkg::CL_OFFSET + 4'h1;
    end
  end

  // Additive latency decode; the reserved code is treated as zero.
  always_comb begin
    case (mr1[ddr3_mode_pkg::MR1_AL_LO +: 2])
      ddr3_mode_pkg::AL_CL_M1: al_val = cl_val - 4'h1;
      ddr3_mode_pkg::AL_CL_M2: al_val = cl_val - 4'h2;
      default:                 al_val = 4'h0;
    endcase
  end

  // Latency outputs come from flops so they are stable for the core.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      cas_lat_o     <= ddr3_mode_pkg::CL_OFFSET + 4'h1;
      cas_wr_lat_o  <= ddr3_mode_pkg::CWL_OFFSET;
      add_lat_o     <= 4'h0;
      rd_lat_o      <= 5'h05;
      wr_lat_o      <= 5'h05;
      cl_invalid_o  <= 1'b0;
      dll_lat_err_o <= 1'b0;
    end else if (ce_i) begin
      cas_lat_o    <= cl_val;
      // Write CAS latency is a whole clock count from MR2.
      cas_wr_lat_o <= {1'b0, mr2[ddr3_mode_pkg::MR2_CWL_LO +: 3]} + ddr3_mode_pkg::CWL_OFFSET;
      add_lat_o    <= al_val;
      // Read and write latency sums.
      rd_lat_o     <= {1'b0, al_val} + {1'b0, cl_val};
      wr_lat_o     <= {1'b0, al_val} + {1'b0, mr2[ddr3_mode_pkg::MR2_CWL_LO +: 3]}
                      + {1'b0, ddr3_mode_pkg::CWL_OFFSET};
      cl_invalid_o <= (cl_code < ddr3_mode_pkg::CL_CODE_MIN)
                      || (cl_code > ddr3_mode_pkg::CL_CODE_MAX);
      // With the DLL off only six clocks is a legal CL or CWL.
      dll_lat_err_o <= !dll_on_o && ((cl_val != ddr3_mode_pkg::DLL_OFF_LAT)
                      || (mr2[ddr3_mode_pkg::MR2_CWL_LO +: 3] != 3'h1));
    end
  end

  // Commands wait AL cycles, then reads wait CL more for first data.
  assign al_rd.pulse_in = rd_cmd_i && ce_i;
  assign al_rd.dly      = add_lat_o;
  assign al_wr.pulse_in = wr_cmd_i && ce_i;
  assign al_wr.dly      = add_lat_o;
  assign cl_rd.pulse_in = al_rd.pulse_out && ce_i;
  assign cl_rd.dly      = cas_lat_o;

  lat_pipe u_al_rd (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce_i), .lp(al_rd.line));
  lat_pipe u_al_wr (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce_i), .lp(al_wr.line));
  lat_pipe u_cl_rd (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce_i), .lp(cl_rd.line));

  // Strobes are handshake outputs and may be combinational.
  assign rd_release_o    = al_rd.pulse_out;
  assign wr_release_o    = al_wr.pulse_out;
  assign rd_data_start_o = cl_rd.pulse_out;

  // Self refresh tracking; the DLL state at entry decides the exit action.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      sr_state      <= ddr3_mode_pkg::SR_IDLE;
      dll_was_on    <= 1'b0;
      sr_exit_reset <= 1'b0;
    end else if (ce_i) begin
      sr_exit_reset <= 1'b0;
      case (sr_state)
        ddr3_mode_pkg::SR_IDLE: begin
          if (sr_enter_i) begin
            sr_state   <= ddr3_mode_pkg::SR_ACTIVE;
            dll_was_on <= !mr1[ddr3_mode_pkg::MR1_DLL_DIS];
          end
        end
        default: begin
          if (sr_exit_i) begin
            sr_state      <= ddr3_mode_pkg::SR_IDLE;
            // Only a DLL that ran before entry is reset on exit.
            sr_exit_reset <= dll_was_on;
          end
        end
      endcase
    end
  end

  // The DLL runs while MR1 enables it and the device is out of self refresh.
  assign dll_on_o = !mr1[ddr3_mode_pkg::MR1_DLL_DIS]
                    && (sr_state == ddr3_mode_pkg::SR_IDLE);

  // A DLL reset comes from an MR0 write with bit 8 set or a self refresh exit when the DLL ran at entry.
  assign dll_reset_req = (mrs_i && mrs_bank_i == ddr3_mode_pkg::MR0_SEL
                          && mrs_addr_i[ddr3_mode_pkg::MR0_DLL_RST])
                         || sr_exit_reset;

  // DLL reset pulse and lock counter; reads before lock give bad timing.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      dll_reset_o <= 1'b0;
      lock_cnt    <= 10'h000;
    end else if (ce_i) begin
      dll_reset_o <= dll_reset_req;
      if (dll_reset_req) begin
        lock_cnt <= ddr3_mode_pkg::DLL_LOCK_CNT;
      end else if (lock_cnt != 10'h000) begin
        lock_cnt <= lock_cnt - 10'h001;
      end
    end
  end
  assign dll_locking_o = (lock_cnt != 10'h000);

  // Nominal termination decode to the RZQ divisor.
  assign rtt_code = {mr1[ddr3_mode_pkg::MR1_RTT_B9], mr1[ddr3_mode_pkg::MR1_RTT_B6],
                     mr1[ddr3_mode_pkg::MR1_RTT_B2]};
  always_comb begin
    case (rtt_code)
      ddr3_mode_pkg::RTT_DIV2:  next_rtt_div = 4'h2;
      ddr3_mode_pkg::RTT_DIV4:  next_rtt_div = 4'h4;
      ddr3_mode_pkg::RTT_DIV6:  next_rtt_div = 4'h6;
      ddr3_mode_pkg::RTT_DIV8:  next_rtt_div = 4'h8;
      ddr3_mode_pkg::RTT_DIV12: next_rtt_div = 4'hC;
      default:                  next_rtt_div = 4'h0;
    endcase
    // Leveling with outputs on leaves only the write-capable values.
    if (mr1[ddr3_mode_pkg::MR1_WLEVEL] && !mr1[ddr3_mode_pkg::MR1_QOFF]
        && (next_rtt_div > 4'h6)) begin
      next_rtt_div = 4'h0;
    end
  end

  // Output buffer and termination controls, all registered.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      drive_sel_o   <= 2'h0;
      dq_drive_en_o <= 1'b1;
      tdqs_en_o     <= 1'b0;
      dm_en_o       <= 1'b1;
      rtt_div_o     <= 4'h0;
      rtt_on_o      <= 1'b0;
      rtt_use_wr_o  <= 1'b0;
      tdqs_term_o   <= 1'b0;
      wlevel_o      <= 1'b0;
    end else if (ce_i) begin
      drive_sel_o   <= {mr1[ddr3_mode_pkg::MR1_DRV_HI], mr1[ddr3_mode_pkg::MR1_DRV_LO]};
      dq_drive_en_o <= !mr1[ddr3_mode_pkg::MR1_QOFF];
      // The strap ignores a TDQS request on x4 or x16 parts.
      tdqs_en_o     <= mr1[ddr3_mode_pkg::MR1_TDQS] && x8_sync;
      dm_en_o       <= !(mr1[ddr3_mode_pkg::MR1_TDQS] && x8_sync);
      rtt_div_o     <= next_rtt_div;
      // The pin gates termination only with a nonzero value and the DLL on.
      rtt_on_o      <= odt_sync && (next_rtt_div != 4'h0) && dll_on_o;
      // During writes a nonzero write termination takes over.
      rtt_use_wr_o  <= odt_sync && wr_burst_i
                       && (mr2[ddr3_mode_pkg::MR2_RTTWR_LO +: 2] != 2'h0) && dll_on_o;
      tdqs_term_o   <= odt_sync && (next_rtt_div != 4'h0) && dll_on_o
                       && mr1[ddr3_mode_pkg::MR1_TDQS] && x8_sync;
      wlevel_o      <= mr1[ddr3_mode_pkg::MR1_WLEVEL];
    end
  end

  // Checks on the latency, DLL, output enable, termination and TDQS behaviour.
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i || !ce_i);

  a_rd_latency_sum: assert property (rd_lat_o == 5'(add_lat_o) + 5'(cas_lat_o))
    else $error("read latency is not AL plus CL");
  a_cl_range_ok: assert property (cas_lat_o >= 4'h5 && cas_lat_o <= 4'hA)
    else $error("CAS latency outside 5 to 10");
  a_mr1_hold_stable: assert property (!$past(mrs_i) |-> $stable(mr1))
    else $error("MR1 changed without an MRS command");
  a_dll_bit_follow: assert property (sr_state == ddr3_mode_pkg::SR_IDLE
    |-> dll_on_o == !mr1[0])
    else $error("DLL state does not follow MR1 bit 0");
  a_sr_dll_off: assert property (sr_state == ddr3_mode_pkg::SR_ACTIVE |-> !dll_on_o)
    else $error("DLL running in self refresh");
  a_sr_exit_reset: assert property (sr_state == ddr3_mode_pkg::SR_ACTIVE && sr_exit_i
    && dll_was_on |-> ##2 dll_reset_o)
    else $error("no DLL reset after self refresh exit");
  a_sr_no_reset: assert property (sr_state == ddr3_mode_pkg::SR_ACTIVE && sr_exit_i
    && !dll_was_on && !mrs_i |-> ##1 !sr_exit_reset)
    else $error("disabled DLL reset on self refresh exit");
  a_lock_counts: assert property (dll_reset_o && !dll_reset_req
    |-> lock_cnt == ddr3_mode_pkg::DLL_LOCK_CNT)
    else $error("DLL lock count not loaded with 512");
  a_mr0_selfclear: assert property (mr0[8] == 1'b0)
    else $error("DLL reset bit did not self-clear");
  a_qoff_tristate: assert property ($past(mr1[12]) |-> !dq_drive_en_o)
    else $error("outputs driven while disabled");
  a_odt_gate_off: assert property (rtt_on_o |-> $past(next_rtt_div) != 4'h0)
    else $error("termination on with zero nominal value");
  a_dll_off_odt: assert property (!$past(dll_on_o) |-> !rtt_on_o)
    else $error("termination on with DLL off");
  // CL 6 with AL at CL minus two puts first data ten cycles after the command.
  a_al_delay_rd: assert property (rd_cmd_i && add_lat_o == 4'h4 && cas_lat_o == 4'h6
    ##1 $stable(add_lat_o) [*2] |-> ##8 rd_data_start_o)
    else $error("read data start not at AL plus CL");
  a_tdqs_dm_excl: assert property (!(tdqs_en_o && dm_en_o))
    else $error("TDQS and DM both enabled");

  c_read_flow: cover property (rd_cmd_i ##[1:20] rd_data_start_o);
  c_sr_cycle: cover property (sr_enter_i && dll_on_o ##[1:50] dll_reset_o);
  c_wlevel_rtt: cover property (wlevel_o && rtt_on_o);

endmodule

// [testbench/ddr3_ctrl_model.sv]
`timescale 1ns/10ps
// Controller side of the MRS path; load cleans MR1 operands before they are issued, issue sends raw ones.
module ddr3_ctrl_model (
  // Clock and organisation strap.
  input  wire logic        clk_sys_i,
  input  wire logic        org_x8_i,
  // Mode register set command.
  output logic             mrs_o,
  output logic [2:0]       bank_o,
  output logic [16:0]      addr_o
);
  logic [16:0] mr0;  // Shadow of MR0, so a DLL reset keeps the latency.

  // Idle bus at time zero.
  initial begin
    mrs_o = 1'b0;
    bank_o = 3'h0;
    addr_o = 17'h00000;
    mr0 = 17'h00010;
  end

  // One raw MRS cycle, launched and released on falling edges.
  task automatic issue(input logic [2:0] b, input logic [16:0] a);
    @(negedge clk_sys_i);
    mrs_o = 1'b1;
    bank_o = b;
    addr_o = a;
    @(negedge clk_sys_i);
    mrs_o = 1'b0;
    // A released operand shows its inverse, so stale values cannot pass.
    bank_o = ~b;
    addr_o = ~a;
  endtask

  // Loads a mode register as a careful controller would.
  task automatic load(input logic [2:0] b, input logic [16:0] a);
    logic [16:0] v;
    v = a;
    if (b == 3'h1) begin
      v = v & ~17'h12500;
      if (org_x8_i !== 1'b1) v[11] = 1'b0;
    end
    if (b == 3'h0) mr0 = v & ~17'h00100;
    // Loads are only called between commands, so all banks are idle then.
    issue(b, v);
    if (b == 3'h1 && v[0] == 1'b0) issue(3'h0, mr0 | 17'h00100);
  endtask
endmodule

// [testbench/test_ddr3_mode_latency_config.sv]
`timescale 1ns/10ps
// Self-checking bench: latencies, MR1 options, termination and DLL handling.
module test_ddr3_mode_latency_config;
  logic        clk_sys_i, rst_i, ce_i, rd_cmd_i, wr_cmd_i;  // Clock and commands.
  logic        sr_enter_i, sr_exit_i, wr_burst_i, odt_pin_i, org_x8_i;
  logic        mrs_i;
  logic [2:0]  mrs_bank_i;
  logic [16:0] mrs_addr_i;
  logic [3:0]  cas_lat_o, cas_wr_lat_o, add_lat_o, rtt_div_o;  // Decoded results.
  logic [4:0]  rd_lat_o, wr_lat_o;
  logic        cl_invalid_o, dll_lat_err_o, rd_release_o, wr_release_o, rd_data_start_o;
  logic        dll_on_o, dll_reset_o, dll_locking_o, dq_drive_en_o, tdqs_en_o, dm_en_o;
  logic        rtt_on_o, rtt_use_wr_o, tdqs_term_o, wlevel_o;
  logic [1:0]  drive_sel_o;
  int          n_errors = 0, n_checks = 0, cycles = 0, tr, td, n;  // Counters and measurements.
  logic [31:0] seed;
  logic [3:0]  cl, alv, dv;
  logic [16:0] v;
  logic [2:0]  cw;

  ddr3_mode_latency_config ddr3_mode_latency_config_inst (.*);
  ddr3_ctrl_model ddr3_ctrl_model_inst (.clk_sys_i(clk_sys_i), .org_x8_i(org_x8_i),
    .mrs_o(mrs_i), .bank_o(mrs_bank_i), .addr_o(mrs_addr_i));

  // Free-running 100 MHz clock.
  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  // Compares one value and reports a mismatch at once.
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Waits k falling edges, then lets the edge's updates settle.
  task automatic wait_n(input int k);
    repeat (k) @(negedge clk_sys_i);
    #1;
  endtask

  // Pulses self refresh entry or exit for one cycle.
  task automatic pulse_sr(input bit ent);
    @(negedge clk_sys_i);
    if (ent) sr_enter_i = 1'b1;
    else sr_exit_i = 1'b1;
    @(negedge clk_sys_i);
    sr_enter_i = 1'b0;
    sr_exit_i = 1'b0;
    #1;
  endtask

  // Sends one column command and measures release and data slots in cycles.
  task automatic run_cmd(input bit rd, output int t_rel, output int t_dat);
    t_rel = -1;
    t_dat = -1;
    // Termination must be off before any read data leaves the device.
    if (rd) odt_pin_i = 1'b0;
    // Reads and writes wait out the DLL lock time; the cycle timeout bounds this wait.
    while (dll_locking_o === 1'b1) @(negedge clk_sys_i);
    @(negedge clk_sys_i);
    if (rd) rd_cmd_i = 1'b1;
    else wr_cmd_i = 1'b1;
    for (int k = 0; k < 24; k++) begin
      #1;
      if (t_rel < 0 && (rd ? rd_release_o : wr_release_o) === 1'b1) t_rel = k;
      if (t_dat < 0 && rd_data_start_o === 1'b1) t_dat = k;
      @(negedge clk_sys_i);
      rd_cmd_i = 1'b0;
      wr_cmd_i = 1'b0;
    end
  endtask

  // Expected CAS latency; invalid codes fall back to five.
  function automatic logic [3:0] exp_cl(input logic [2:0] c);
    return (c >= 3'h1 && c <= 3'h6) ? 4'(c) + 4'h4 : 4'h5;
  endfunction

  // Expected RZQ divisor; leveling with outputs on allows only the write values.
  function automatic logic [3:0] exp_div(input logic [2:0] c, input logic lim);
    case (c)
      3'h1: return 4'h4;
      3'h2: return 4'h2;
      3'h3: return 4'h6;
      3'h4: return lim ? 4'h0 : 4'hC;
      3'h5: return lim ? 4'h0 : 4'h8;
      default: return 4'h0;
    endcase
  endfunction

  // A hang counts as a mismatch and goes to the closing report.
  always @(posedge clk_sys_i) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      n_errors++;
      tally_and_finish();
    end
  end

  // Main sequence.
  initial begin
    seed = 32'hf4d6;
    {rd_cmd_i, wr_cmd_i, sr_enter_i, sr_exit_i, wr_burst_i, odt_pin_i, org_x8_i} = '0;
    ce_i = 1'b1;
    rst_i = 1'b1;
    repeat (3) @(negedge clk_sys_i);
    rst_i = 1'b0;
    #1;
    check("cas_lat", cas_lat_o, 32'h5);
    check("rd_lat", rd_lat_o, 32'h5);
    check("dll_on", dll_on_o, 32'h1);
    // Every CL code, every AL code, random CWL; read release, read data and write release measured.
    for (int i = 0; i < 8; i++) begin
      cw = 3'($random(seed)) & 3'h3;
      ddr3_ctrl_model_inst.load(3'h2, {11'h000, cw, 3'h0});
      ddr3_ctrl_model_inst.load(3'h1, {12'h000, 2'(i), 3'h0});
      ddr3_ctrl_model_inst.load(3'h0, {10'h000, 3'(i), 4'h0});
      wait_n(2);
      cl = exp_cl(3'(i));
      alv = (2'(i) == 2'h1) ? cl - 4'h1 : (2'(i) == 2'h2) ? cl - 4'h2 : 4'h0;
      check("cas_lat", cas_lat_o, 32'(cl));
      check("cl_invalid", cl_invalid_o, 32'(i == 0 || i == 7));
      check("add_lat", add_lat_o, 32'(alv));
      check("cas_wr_lat", cas_wr_lat_o, 32'(cw) + 32'h5);
      check("rd_lat", rd_lat_o, 32'(alv) + 32'(cl));
      check("wr_lat", wr_lat_o, 32'(alv) + 32'(cw) + 32'h5);
      run_cmd(1'b1, tr, td);
      check("rd_release", tr, 32'(alv));
      check("rd_data", td, 32'(alv) + 32'(cl));
      run_cmd(1'b0, tr, td);
      check("wr_release", tr, 32'(alv));
    end
    // Random MR1 option sets with the DLL kept on, then the ODT pin.
    for (int i = 0; i < 12; i++) begin
      @(negedge clk_sys_i);
      org_x8_i = 1'($random(seed));
      wait_n(3);
      v = 17'($random(seed)) & ~17'h00019;
      ddr3_ctrl_model_inst.load(3'h1, v);
      wait_n(2);
      v = v & ~17'h12500;
      if (!org_x8_i) v[11] = 1'b0;
      dv = exp_div({v[9], v[6], v[2]}, v[7] & ~v[12]);
      check("drive_sel", drive_sel_o, {v[5], v[1]});
      check("dq_drive_en", dq_drive_en_o, 32'(!v[12]));
      check("tdqs_en", tdqs_en_o, v[11]);
      check("dm_en", dm_en_o, 32'(!v[11]));
      if (!v[11]) check("tdqs_term", tdqs_term_o, 32'h0);
      check("wlevel", wlevel_o, v[7]);
      check("rtt_div", rtt_div_o, 32'(dv));
      odt_pin_i = 1'b1;
      wait_n(4);
      check("rtt_on", rtt_on_o, 32'(dv != 4'h0));
      check("tdqs_term", tdqs_term_o, 32'(v[11] && dv != 4'h0));
      odt_pin_i = 1'b0;
      wait_n(4);
      check("rtt_on", rtt_on_o, 32'h0);
    end
    // Dynamic termination during a write window, with and without RTT_WR.
    ddr3_ctrl_model_inst.load(3'h1, 17'h00004);
    for (int w = 0; w < 2; w++) begin
      ddr3_ctrl_model_inst.load(3'h2, w ? 17'h00200 : 17'h00000);
      odt_pin_i = 1'b1;
      wr_burst_i = 1'b1;
      wait_n(4);
      check("rtt_use_wr", rtt_use_wr_o, 32'(w));
      wr_burst_i = 1'b0;
      odt_pin_i = 1'b0;
    end
    // DLL off with both latencies at six, then a deliberate CL of five.
    ddr3_ctrl_model_inst.load(3'h2, 17'h00008);
    ddr3_ctrl_model_inst.load(3'h0, 17'h00020);
    ddr3_ctrl_model_inst.load(3'h1, 17'h00001);
    wait_n(2);
    check("dll_on", dll_on_o, 32'h0);
    check("dll_lat_err", dll_lat_err_o, 32'h0);
    ddr3_ctrl_model_inst.issue(3'h0, 17'h00010);
    wait_n(2);
    check("dll_lat_err", dll_lat_err_o, 32'h1);
    // Self refresh with the DLL already off leaves it off, with no reset.
    pulse_sr(1'b1);
    wait_n(3);
    pulse_sr(1'b0);
    check("dll_on", dll_on_o, 32'h0);
    wait_n(1);
    check("dll_reset", dll_reset_o, 32'h0);
    // Enabling brings the DLL reset; the lock window lasts 512 cycles.
    ddr3_ctrl_model_inst.load(3'h1, 17'h00000);
    check("dll_reset", dll_reset_o, 32'h1);
    n = 0;
    while (dll_locking_o === 1'b1 && n < 600) begin
      n++;
      wait_n(1);
    end
    check("lock_cycles", n, 32'd512);
    // Self refresh with the DLL on stops it and resets it on exit.
    pulse_sr(1'b1);
    check("dll_on", dll_on_o, 32'h0);
    wait_n(3);
    pulse_sr(1'b0);
    check("dll_on", dll_on_o, 32'h1);
    wait_n(1);
    check("dll_reset", dll_reset_o, 32'h1);
    // An unmapped bank changes nothing; reset then clears MR1.
    ddr3_ctrl_model_inst.load(3'h1, 17'h00080);
    ddr3_ctrl_model_inst.issue(3'h5, 17'h1FFFF);
    wait_n(2);
    check("dq_drive_en", dq_drive_en_o, 32'h1);
    check("wlevel", wlevel_o, 32'h1);
    // A low clock enable freezes the registers, so an MRS meanwhile is lost.
    @(negedge clk_sys_i);
    ce_i = 1'b0;
    ddr3_ctrl_model_inst.issue(3'h1, 17'h01000);
    wait_n(1);
    ce_i = 1'b1;
    wait_n(2);
    check("dq_drive_en", dq_drive_en_o, 32'h1);
    rst_i = 1'b1;
    wait_n(2);
    rst_i = 1'b0;
    wait_n(1);
    check("wlevel", wlevel_o, 32'h0);
    tally_and_finish();
  end
endmodule
